// File: design/tbb_pkg.sv
// Purpose: Constants for the two-wire bus buffer connection controller
// Assumes: core clock of 10 MHz
// Notes:   Times kept in their own units, cycle counts derived from them
package tbb_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned STUCK_MS        = 30;
    localparam int unsigned IDLE_US         = 95;
    localparam int unsigned RECOV_WAIT_US   = 40;
    localparam int unsigned RECOV_CLK_HZ    = 8_500;
    localparam int unsigned RECOV_PULSES    = 16;
    // Least times and periods both round down
    localparam int unsigned STUCK_CYC   = STUCK_MS * (CLK_HZ / 1_000);
    localparam int unsigned IDLE_CYC    = IDLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAIT_CYC    = (RECOV_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned HALF_CYC    = CLK_HZ / (2 * RECOV_CLK_HZ);
    localparam int unsigned CNT_W       = 24;
    localparam logic        RESET_CONN  = 1'b0;

    typedef enum logic [2:0] {
        TBB_LOCKOUT,
        TBB_WAIT_END,
        TBB_WAIT_CARD,
        TBB_CONNECTED,
        TBB_RECOV_WAIT,
        TBB_RECOV_CLK,
        TBB_STUCK
    } tbb_state_t;
endpackage

// File: design/tbb_top.sv
// Purpose: Connection controller for a hot-insertable two-wire bus buffer
// Assumes: Open-drain lines given as input level plus pull-low enable
// Notes:   Analog offset, precharge level and accelerator current omitted
// How it works
// - Enable low isolates, ready low, no recovery
// - Enable rise after fault connects at once
// - Supply lockout ignores all bus activity
// - Precharge asserted during lockout
// - Stop or idle ends backplane transaction
// - Connect when card lines high; ready high
// - Any low on a pair pulls both
// - Pair high only when all release
// - Card line low runs stuck timer
// - Timer cleared when both card high, in lockout or on enable rise after fault
// - Stuck 30ms opens the connection
// - After 40us, up to 16 recovery clocks
// - Reconnect via start-up conditions again or at once on enable rise
// - Stuck at power-up: recover 30ms after lockout
// - Enable rise after fault restarts timer
// - Accelerators off during recovery clocking
// - Ready tracks connection state
// - Enable high waits for end and card high
`timescale 1ns/1ps
module tbb_top
    import tbb_pkg::*;
#(
    parameter int unsigned STUCK_CYCLES = tbb_pkg::STUCK_CYC,
    parameter int unsigned IDLE_CYCLES  = tbb_pkg::IDLE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic supply_good,
    input  wire logic enable,
    input  wire logic backplane_data_line_i,
    output logic      backplane_data_line_oe,
    input  wire logic backplane_clock_line_i,
    output logic      backplane_clock_line_oe,
    input  wire logic card_data_line_i,
    output logic      card_data_line_oe,
    input  wire logic card_clock_line_i,
    output logic      card_clock_line_oe,
    output logic      ready_oe,
    output logic      precharge_en,
    output logic      accel_en
);
    import tbb_pkg::*;

    // Two-flop synchronisers; first stage read only by second
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // Supply and enable read low after reset: no false exit or edge
            s1_r <= 6'h0f;
            s2_r <= 6'h0f;
        end else begin
            s1_r <= {supply_good, enable, backplane_data_line_i, backplane_clock_line_i,
                     card_data_line_i, card_clock_line_i};
            s2_r <= s1_r;
        end
    end
    logic sup, en, bd, bc, cd, cc;
    assign {sup, en, bd, bc, cd, cc} = s2_r;

    // Own drive is excluded from the sensed level to avoid a latch-up
    // loop; the sensed level lags our drive by the two sync stages, so
    // the mask is held two cycles past the release.
    logic bd_own_r, bc_own_r, cd_own_r, cc_own_r;
    logic [1:0] bd_hist_r, bc_hist_r, cd_hist_r, cc_hist_r;
    logic bd_ext, bc_ext, cd_ext, cc_ext;
    assign bd_ext = bd | bd_own_r | (|bd_hist_r);
    assign bc_ext = bc | bc_own_r | (|bc_hist_r);
    assign cd_ext = cd | cd_own_r | (|cd_hist_r);
    assign cc_ext = cc | cc_own_r | (|cc_hist_r);

    logic en_d_r, bd_d_r;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            en_d_r <= 1'b0;
            bd_d_r <= 1'b1;
        end else begin
            en_d_r <= en;
            bd_d_r <= bd;
        end
    end
    logic en_rise;
    assign en_rise = en & ~en_d_r;

    tbb_state_t state_r;
    logic       fault_r;
    logic [CNT_W-1:0] idle_cnt_r;
    logic [CNT_W-1:0] stuck_cnt_r;
    logic [CNT_W-1:0] tmr_r;
    logic [4:0]       pulse_cnt_r;
    logic             recov_low_r;

    // Stop: data rises while clock high; idle: both high long enough
    logic stop_seen;
    logic idle_seen;
    assign stop_seen = bd & ~bd_d_r & bc;
    assign idle_seen = (idle_cnt_r >= CNT_W'(IDLE_CYCLES));

    always_ff @(posedge core_clk) begin
        // Idle is timed afresh on each wait, so enable rise waits it out
        if (!rst_b || state_r != TBB_WAIT_END || !en || !(bd && bc))
            idle_cnt_r <= '0;
        else if (!idle_seen)
            idle_cnt_r <= idle_cnt_r + 1'b1;
    end

    logic card_high;
    logic stuck_hit;
    assign card_high = cd & cc;
    assign stuck_hit = (stuck_cnt_r >= CNT_W'(STUCK_CYCLES));

    // Timer runs on any card low, clears with both high, in lockout or on enable rise after fault
    always_ff @(posedge core_clk) begin
        if (!rst_b || state_r == TBB_LOCKOUT)
            stuck_cnt_r <= '0;
        else if (card_high)
            stuck_cnt_r <= '0;
        else if (en_rise && fault_r)
            stuck_cnt_r <= '0;
        else if (!stuck_hit)
            stuck_cnt_r <= stuck_cnt_r + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r     <= TBB_LOCKOUT;
            fault_r     <= 1'b0;
            tmr_r       <= '0;
            pulse_cnt_r <= '0;
            recov_low_r <= 1'b0;
        end else if (!sup) begin
            state_r     <= TBB_LOCKOUT;
            fault_r     <= 1'b0;
            recov_low_r <= 1'b0;
        end else if (!en) begin
            // Isolate; recovery suppressed while low
            recov_low_r <= 1'b0;
            if (state_r != TBB_LOCKOUT && state_r != TBB_STUCK)
                state_r <= TBB_WAIT_END;
        end else if (en_rise && fault_r) begin
            state_r     <= TBB_CONNECTED;
            fault_r     <= 1'b0;
            recov_low_r <= 1'b0;
        end else begin
            unique case (state_r)
                TBB_LOCKOUT: state_r <= TBB_WAIT_END;
                TBB_WAIT_END: begin
                    if (stuck_hit) begin
                        fault_r <= 1'b1;
                        tmr_r   <= '0;
                        state_r <= TBB_RECOV_WAIT;
                    end else if (stop_seen || idle_seen)
                        state_r <= TBB_WAIT_CARD;
                end
                TBB_WAIT_CARD: begin
                    if (stuck_hit) begin
                        fault_r <= 1'b1;
                        tmr_r   <= '0;
                        state_r <= TBB_RECOV_WAIT;
                    end else if (card_high)
                        state_r <= TBB_CONNECTED;
                end
                TBB_CONNECTED: begin
                    if (stuck_hit) begin
                        fault_r <= 1'b1;
                        tmr_r   <= '0;
                        state_r <= TBB_RECOV_WAIT;
                    end
                end
                TBB_RECOV_WAIT: begin
                    if (card_high)
                        state_r <= TBB_WAIT_END;
                    else if (tmr_r >= CNT_W'(WAIT_CYC) - 1'b1) begin
                        tmr_r       <= '0;
                        pulse_cnt_r <= '0;
                        recov_low_r <= 1'b0;
                        state_r     <= TBB_RECOV_CLK;
                    end else
                        tmr_r <= tmr_r + 1'b1;
                end
                TBB_RECOV_CLK: begin
                    if (tmr_r >= CNT_W'(HALF_CYC) - 1'b1) begin
                        tmr_r <= '0;
                        if (!recov_low_r) begin
                            // Data high at end of a high phase ends early
                            if (cd_ext || pulse_cnt_r == 5'(RECOV_PULSES))
                                state_r <= TBB_STUCK;
                            else begin
                                recov_low_r <= 1'b1;
                                pulse_cnt_r <= pulse_cnt_r + 1'b1;
                            end
                        end else
                            recov_low_r <= 1'b0;
                    end else
                        tmr_r <= tmr_r + 1'b1;
                end
                TBB_STUCK: begin
                    if (card_high)
                        state_r <= TBB_WAIT_END;
                end
            endcase
        end
    end

    logic connected;
    assign connected = (state_r == TBB_CONNECTED) && en && sup;

    // Wired-AND of each pair: an outside low drives the far side
    logic bd_pull, bc_pull, cd_pull, cc_pull;
    assign bd_pull = connected & ~cd_ext;
    assign cd_pull = connected & ~bd_ext;
    assign bc_pull = connected & ~cc_ext;
    assign cc_pull = (connected & ~bc_ext) |
                     ((state_r == TBB_RECOV_CLK) & recov_low_r & en);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bd_own_r <= 1'b0;
            bc_own_r <= 1'b0;
            cd_own_r <= 1'b0;
            cc_own_r <= 1'b0;
            bd_hist_r <= 2'b00;
            bc_hist_r <= 2'b00;
            cd_hist_r <= 2'b00;
            cc_hist_r <= 2'b00;
            backplane_data_line_oe  <= 1'b0;
            backplane_clock_line_oe <= 1'b0;
            card_data_line_oe       <= 1'b0;
            card_clock_line_oe      <= 1'b0;
            ready_oe     <= 1'b1;
            precharge_en <= 1'b1;
            accel_en     <= 1'b0;
        end else begin
            bd_own_r <= bd_pull;
            bc_own_r <= bc_pull;
            cd_own_r <= cd_pull;
            cc_own_r <= cc_pull;
            bd_hist_r <= {bd_hist_r[0], bd_own_r};
            bc_hist_r <= {bc_hist_r[0], bc_own_r};
            cd_hist_r <= {cd_hist_r[0], cd_own_r};
            cc_hist_r <= {cc_hist_r[0], cc_own_r};
            backplane_data_line_oe  <= bd_pull;
            backplane_clock_line_oe <= bc_pull;
            card_data_line_oe       <= cd_pull;
            card_clock_line_oe      <= cc_pull;
            ready_oe     <= ~connected;
            precharge_en <= (state_r == TBB_LOCKOUT) | ~sup;
            accel_en     <= connected & (state_r != TBB_RECOV_CLK);
        end
    end
endmodule // tbb_top

// File: verif/tbb_checker_assertions.sv
// Purpose: Port checker for the bus buffer controller
// Assumes: One core clock domain, sync active-low reset
// Notes:   Windows allow about five cycles of sync latency
`timescale 1ns/1ps
module tbb_checker
#(
    parameter int unsigned STUCK_CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic supply_good,
    input wire logic enable,
    input wire logic backplane_data_line_i,
    input wire logic backplane_data_line_oe,
    input wire logic backplane_clock_line_i,
    input wire logic backplane_clock_line_oe,
    input wire logic card_data_line_i,
    input wire logic card_data_line_oe,
    input wire logic card_clock_line_i,
    input wire logic card_clock_line_oe,
    input wire logic ready_oe,
    input wire logic precharge_en,
    input wire logic accel_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic       any_oe;
    logic [23:0] low_cnt_r;
    assign any_oe = backplane_data_line_oe | backplane_clock_line_oe
                  | card_data_line_oe | card_clock_line_oe;
    // Cleared by enable low too, since a forced reconnect restarts the timer
    always_ff @(posedge core_clk) begin
        if (!rst_b || !enable || !supply_good || (card_data_line_i && card_clock_line_i)) begin
            low_cnt_r <= 24'h00_0000;
        end else begin
            low_cnt_r <= low_cnt_r + 24'h00_0001;
        end
    end
    a_lockout_isolates: assert property (precharge_en && $past(precharge_en) |-> ready_oe && !accel_en && !any_oe)
        else $error("bus driven during lockout");
    a_precharge_lockout: assert property (!supply_good [*6] |-> precharge_en)
        else $error("precharge off in lockout");
    a_enable_low_isolates: assert property (!enable [*6] |-> ready_oe && !any_oe && !accel_en)
        else $error("not isolated with enable low");
    a_ready_tracks_conn: assert property (accel_en && $past(accel_en) |-> !ready_oe)
        else $error("accelerators on without ready");
    a_data_low_joins: assert property ((!ready_oe && !card_data_line_i && !card_data_line_oe) [*5] |-> backplane_data_line_oe)
        else $error("card data low not passed across");
    a_clock_low_joins: assert property ((!ready_oe && !backplane_clock_line_i && !backplane_clock_line_oe) [*5] |-> card_clock_line_oe)
        else $error("backplane clock low not passed across");
    a_data_release: assert property ((!ready_oe && card_data_line_i) [*5] |-> !backplane_data_line_oe)
        else $error("data held low after release");
    a_recov_no_accel: assert property (card_clock_line_oe && ready_oe |-> !accel_en)
        else $error("accelerators on during recovery");
    a_stuck_opens: assert property (low_cnt_r == 24'(STUCK_CYCLES + 8) |-> ready_oe)
        else $error("stuck card not disconnected");
endmodule // tbb_checker

bind tbb_top tbb_checker #(.STUCK_CYCLES(STUCK_CYCLES)) u_chk (
    .core_clk, .rst_b, .supply_good, .enable, .backplane_data_line_i, .backplane_data_line_oe,
    .backplane_clock_line_i, .backplane_clock_line_oe, .card_data_line_i, .card_data_line_oe,
    .card_clock_line_i, .card_clock_line_oe, .ready_oe, .precharge_en, .accel_en);

// File: verif/tbb_bus_model.sv
// Purpose: Backplane and card parties on two open-drain pairs
// Assumes: Pull-ups on every line
// Notes:   Released line reads high, never the last value
`timescale 1ns/1ps
module tbb_bus_model (
    input  wire logic bp_data_pull,
    input  wire logic bp_clock_pull,
    input  wire logic card_data_pull,
    input  wire logic card_clock_pull,
    input  wire logic [3:0] dut_oe,
    output logic      bp_data,
    output logic      bp_clock,
    output logic      card_data,
    output logic      card_clock
);
    assign bp_data    = !(bp_data_pull || dut_oe[3]);
    assign bp_clock   = !(bp_clock_pull || dut_oe[2]);
    assign card_data  = !(card_data_pull || dut_oe[1]);
    assign card_clock = !(card_clock_pull || dut_oe[0]);
endmodule // tbb_bus_model

// File: verif/testbench.sv
// Purpose: Self-checking bench for the bus buffer controller
// Assumes: Short stuck and idle counts (200 and 20 cycles)
// Notes:   Backplane frame clock runs at 800 ns only inside frames
`timescale 1ns/1ps
module testbench;
    import tbb_pkg::*;
    logic core_clk, rst_b, supply_good, enable, bdp, bcp, cdp, ccp;
    logic bd, bc, cd, cc, bd_oe, bc_oe, cd_oe, cc_oe, ready_oe, prev, pre, acc;
    logic [15:0] seed;
    int miscompares, check_count, i, n, first;
    tbb_top #(.STUCK_CYCLES(200), .IDLE_CYCLES(20)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .supply_good(supply_good), .enable(enable),
        .backplane_data_line_i(bd), .backplane_data_line_oe(bd_oe),
        .backplane_clock_line_i(bc), .backplane_clock_line_oe(bc_oe),
        .card_data_line_i(cd), .card_data_line_oe(cd_oe),
        .card_clock_line_i(cc), .card_clock_line_oe(cc_oe),
        .ready_oe(ready_oe), .precharge_en(pre), .accel_en(acc));
    tbb_bus_model i_bus (
        .bp_data_pull(bdp), .bp_clock_pull(bcp), .card_data_pull(cdp), .card_clock_pull(ccp),
        .dut_oe({bd_oe, bc_oe, cd_oe, cc_oe}),
        .bp_data(bd), .bp_clock(bc), .card_data(cd), .card_clock(cc));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #5;
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 3000 && ready_oe !== 1'b0; k++) step(1);
    endtask
    task automatic conclude();
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        conclude();
    end
    initial begin
        {rst_b, supply_good, enable, bdp, bcp, cdp, ccp} = 7'h00;
        seed = 16'hf167;
        step(5);
        rst_b = 1'b1;
        bdp = 1'b1;
        step(10);
        check({bd_oe, bc_oe, cd_oe, cc_oe}, 4'h0);
        check(4'(pre), 4'h1);
        bdp = 1'b0;
        supply_good = 1'b1;
        enable = 1'b1;
        step(4);
        // Backplane frame: data held low, eight clocks, then stop
        bdp = 1'b1;
        for (i = 0; i < 16; i++) begin
            step(4);
            bcp = ~bcp;
        end
        step(4);
        check(4'(ready_oe), 4'h1);
        bdp = 1'b0;
        step(10);
        check(4'(ready_oe), 4'h0);
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            {bdp, bcp, cdp, ccp} = seed[2] ? 4'h8 >> seed[1:0] : 4'h0;
            step(6);
            check({cd_oe, cc_oe, bd_oe, bc_oe}, {bdp, bcp, cdp, ccp});
            {bdp, bcp, cdp, ccp} = 4'h0;
            step(6);
            check({cd_oe, cc_oe, bd_oe, bc_oe}, 4'h0);
        end
        enable = 1'b0;
        step(8);
        check(4'(ready_oe), 4'h1);
        enable = 1'b1;
        step(8);
        check(4'(ready_oe), 4'h1);
        wait_ready();
        check(4'(ready_oe), 4'h0);
        step(1);
        check(4'(acc), 4'h1);
        cdp = 1'b1;
        step(190);
        check(4'(ready_oe), 4'h0);
        step(20);
        check(4'(ready_oe), 4'h1);
        n = 0;
        first = 0;
        for (i = 0; i < 21000; i++) begin
            prev = cc_oe;
            step(1);
            if (cc_oe && !prev) begin
                if (n == 0) first = i;
                if (n == 0) check(4'(acc), 4'h0);
                n++;
            end
        end
        check({3'h0, n == 16}, 4'h1);
        check({3'h0, first >= WAIT_CYC}, 4'h1);
        enable = 1'b0;
        step(8);
        enable = 1'b1;
        step(8);
        check(4'(ready_oe), 4'h0);
        step(150);
        check(4'(ready_oe), 4'h0);
        step(60);
        check(4'(ready_oe), 4'h1);
        cdp = 1'b0;
        wait_ready();
        check(4'(ready_oe), 4'h0);
        supply_good = 1'b0;
        step(8);
        check(4'(ready_oe), 4'h1);
        check(4'(pre), 4'h1);
        conclude();
    end
endmodule // testbench
